// ### ipfes_top.sv
// External request flags, enables, sense control and priority registers
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps

module ipfes_top (
    input  wire logic                             clk_i,
    input  wire logic                             rst_n_i,
    input  wire logic                             standby_n_i,
    input  wire logic [ipfes_pkg::NUM_IRQ-1:0]    irq_n_i,
    input  wire logic [ipfes_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [ipfes_pkg::DATA_W-1:0]     wdata_i,
    input  wire logic                             wr_i,
    input  wire logic                             rd_i,
    input  wire logic                             ack_i,
    output logic      [ipfes_pkg::DATA_W-1:0]     rdata_o,
    output logic                                  req_valid_o,
    output logic      [7:0]                       req_vector_o,
    output logic                                  req_level_o,
    output logic      [4:0]                       timer_prio_o,
    output logic                                  dma_prio_o,
    output logic      [1:0]                       serial_prio_o,
    output logic                                  converter_prio_o
);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [5:0] pin_s1;
        logic [5:0] pin_s2;
        logic [5:0] pin_prev;
        logic       stby_s1;
        logic       stby_s2;
        logic [7:0] prio_a;
        logic [7:0] prio_b;
        logic [5:0] flags;
        logic [7:0] enable;
        logic [7:0] sense;
        logic [5:0] seen;
        logic [7:0] rdata;
        logic       req_valid;
        logic [2:0] req_index;
        logic       req_level;
        logic [7:0] req_vector;
    } ipfes_state_t;

    localparam ipfes_state_t ST_RESET = '{
        pin_s1:    6'h3f,
        pin_s2:    6'h3f,
        pin_prev:  6'h3f,
        stby_s1:   1'b1,
        stby_s2:   1'b1,
        prio_a:    ipfes_pkg::RST_REG,
        prio_b:    ipfes_pkg::RST_REG,
        flags:     ipfes_pkg::RST_FLAGS,
        enable:    ipfes_pkg::RST_REG,
        sense:     ipfes_pkg::RST_REG,
        seen:      ipfes_pkg::RST_FLAGS,
        rdata:     ipfes_pkg::RST_REG,
        req_valid: 1'b0,
        req_index: 3'h0,
        req_level: 1'b0,
        req_vector: ipfes_pkg::VEC_BASE
    };

    ipfes_state_t st;
    ipfes_state_t next_st;

    logic [5:0] fall;
    logic [5:0] set_ev;
    logic [5:0] ack_hit;
    logic [5:0] auto_clr;
    logic [5:0] sw_clr;
    logic [5:0] pend;
    logic [5:0] ext_level;
    logic       flags_wr;

    // --------------------------------------------------------------
    // Per-request level from the upper priority A bits
    // --------------------------------------------------------------
    function automatic logic [5:0] ext_levels(input logic [7:0] pa);
        logic [5:0] lv;
        lv    = 6'h00;
        lv[0] = pa[ipfes_pkg::PA_IRQ0_BIT];
        lv[1] = pa[ipfes_pkg::PA_IRQ1_BIT];
        lv[2] = pa[ipfes_pkg::PA_IRQ23_BIT];
        lv[3] = pa[ipfes_pkg::PA_IRQ23_BIT];
        lv[4] = pa[ipfes_pkg::PA_IRQ45_BIT];
        lv[5] = pa[ipfes_pkg::PA_IRQ45_BIT];
        return lv;
    endfunction

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Pins are asynchronous: two stages, then an edge history stage
        next_st.pin_s1   = irq_n_i;
        next_st.pin_s2   = st.pin_s1;
        next_st.pin_prev = st.pin_s2;
        next_st.stby_s1  = standby_n_i;
        next_st.stby_s2  = st.stby_s1;

        fall     = st.pin_prev & ~st.pin_s2;
        flags_wr = wr_i && (addr_i == ipfes_pkg::OFS_FLAGS);
        ack_hit  = 6'h00;
        if (ack_i && st.req_valid) begin
            ack_hit[st.req_index] = 1'b1;
        end

        for (int i = 0; i < ipfes_pkg::NUM_IRQ; i++) begin
            set_ev[i]   = st.sense[i] ? fall[i] : ~st.pin_s2[i];
            auto_clr[i] = ack_hit[i] && (st.sense[i] || st.pin_s2[i]);
            sw_clr[i]   = flags_wr && !wdata_i[i] && st.seen[i];
            // A new event in the clearing cycle wins over the clear
            next_st.flags[i] = set_ev[i] || (st.flags[i] && !(auto_clr[i] || sw_clr[i]));
        end

        // Read-then-write tracking; a flag serviced meanwhile drops its mark
        if (rd_i && (addr_i == ipfes_pkg::OFS_FLAGS)) begin
            next_st.seen = st.flags;
        end else if (flags_wr) begin
            next_st.seen = ipfes_pkg::RST_FLAGS;
        end
        next_st.seen = next_st.seen & ~auto_clr;

        if (wr_i) begin
            unique case (addr_i)
                ipfes_pkg::OFS_SENSE:  next_st.sense  = wdata_i;
                ipfes_pkg::OFS_ENABLE: next_st.enable = wdata_i;
                ipfes_pkg::OFS_PRIO_A: next_st.prio_a = wdata_i;
                ipfes_pkg::OFS_PRIO_B: next_st.prio_b = wdata_i;
                default: ;
            endcase
        end

        // Read data live for exactly one cycle
        next_st.rdata = ipfes_pkg::READ_UNMAP;
        if (rd_i) begin
            unique case (addr_i)
                ipfes_pkg::OFS_SENSE:  next_st.rdata = st.sense;
                ipfes_pkg::OFS_ENABLE: next_st.rdata = st.enable;
                ipfes_pkg::OFS_FLAGS:  next_st.rdata = {ipfes_pkg::FLAGS_RSVD, st.flags};
                ipfes_pkg::OFS_PRIO_A: next_st.rdata = st.prio_a;
                ipfes_pkg::OFS_PRIO_B: next_st.rdata = st.prio_b;
                default:               next_st.rdata = ipfes_pkg::READ_UNMAP;
            endcase
        end

        // Hardware standby clears every register, as reset does
        if (!st.stby_s2) begin
            next_st.prio_a = ipfes_pkg::RST_REG;
            next_st.prio_b = ipfes_pkg::RST_REG;
            next_st.flags  = ipfes_pkg::RST_FLAGS;
            next_st.enable = ipfes_pkg::RST_REG;
            next_st.sense  = ipfes_pkg::RST_REG;
            next_st.seen   = ipfes_pkg::RST_FLAGS;
        end

        // Arbitrate on the updated flags so a serviced request drops at once
        pend      = next_st.flags & next_st.enable[5:0];
        ext_level = ext_levels(next_st.prio_a);
        next_st.req_valid = |pend;
        next_st.req_level = |(pend & ext_level);
        next_st.req_index = 3'h0;
        for (int i = ipfes_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (pend[i] && (ext_level[i] == next_st.req_level)) begin
                next_st.req_index = 3'(i);
            end
        end
        // Vector kept in a flop so the output carries no adder after the register
        next_st.req_vector = ipfes_pkg::VEC_BASE + {5'h00, next_st.req_index};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign rdata_o      = st.rdata;
    assign req_valid_o  = st.req_valid;
    assign req_level_o  = st.req_level;
    assign req_vector_o = st.req_vector;
    assign timer_prio_o = {st.prio_b[ipfes_pkg::PB_TIMER4_BIT],
                           st.prio_b[ipfes_pkg::PB_TIMER3_BIT],
                           st.prio_a[ipfes_pkg::PA_TIMER2_BIT],
                           st.prio_a[ipfes_pkg::PA_TIMER1_BIT],
                           st.prio_a[ipfes_pkg::PA_TIMER0_BIT]};
    assign dma_prio_o       = st.prio_b[ipfes_pkg::PB_DMA_BIT];
    assign serial_prio_o    = {st.prio_b[ipfes_pkg::PB_SERIAL1_BIT],
                               st.prio_b[ipfes_pkg::PB_SERIAL0_BIT]};
    assign converter_prio_o = st.prio_b[ipfes_pkg::PB_CONV_BIT];

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_flag_rsvd_zero: assert property (
        rd_i && (addr_i == ipfes_pkg::OFS_FLAGS) |=> rdata_o[7:6] == 2'h0 && rdata_o[5:0] == $past(st.flags))
        else $error("flag register read returned bad value");

    a_prio_b_standby: assert property (
        !st.stby_s2 |=> st.prio_b == 8'h00 && st.flags == 6'h00 && st.enable == 8'h00)
        else $error("standby did not clear registers");

    a_prio_b_store: assert property (
        wr_i && (addr_i == ipfes_pkg::OFS_PRIO_B) && st.stby_s2 ##1 rd_i && (addr_i == ipfes_pkg::OFS_PRIO_B)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("priority B did not read back written value");

    a_req_enabled: assert property (
        req_valid_o |-> st.flags[st.req_index] && st.enable[st.req_index])
        else $error("request presented without flag and enable");

    a_high_first: assert property (
        req_valid_o && !req_level_o |-> (st.flags & st.enable[5:0] & ext_levels(st.prio_a)) == 6'h00)
        else $error("low level presented while high pending");

    a_vector_range: assert property (
        req_valid_o |-> req_vector_o >= 8'h0c && req_vector_o <= 8'h11)
        else $error("vector outside external range");

    a_smallest_wins: assert property (
        req_valid_o |-> ((st.flags & st.enable[5:0] & ((6'h01 << st.req_index) - 6'h01)
                          & (req_level_o ? ext_levels(st.prio_a) : ~ext_levels(st.prio_a))) == 6'h00))
        else $error("larger vector won at same level");

    generate
        for (genvar g = 0; g < ipfes_pkg::NUM_IRQ; g++) begin : g_chk
            a_level_sets: assert property (
                st.stby_s2 && !st.sense[g] && !st.pin_s2[g] |=> st.flags[g])
                else $error("low level did not set flag");

            a_edge_sets: assert property (
                st.stby_s2 && st.sense[g] && st.pin_prev[g] && !st.pin_s2[g] |=> st.flags[g])
                else $error("falling edge did not set flag");

            a_one_no_set: assert property (
                wr_i && (addr_i == ipfes_pkg::OFS_FLAGS) && wdata_i[g] && !st.flags[g]
                && st.sense[g] && !(st.pin_prev[g] && !st.pin_s2[g]) |=> !st.flags[g])
                else $error("writing one set a flag");

            a_clear_cause: assert property (
                $fell(st.flags[g]) |-> $past(!st.stby_s2) || $past(ack_hit[g])
                || $past(wr_i && addr_i == ipfes_pkg::OFS_FLAGS && !wdata_i[g] && st.seen[g]))
                else $error("flag cleared without cause");

            a_edge_ack_clr: assert property (
                ack_hit[g] && st.sense[g] && !(st.pin_prev[g] && !st.pin_s2[g]) |=> !st.flags[g])
                else $error("service did not clear edge flag");

            a_level_ack_clr: assert property (
                ack_hit[g] && !st.sense[g] && st.pin_s2[g] |=> !st.flags[g])
                else $error("service with pin high did not clear level flag");
        end
    endgenerate

    c_edge_set:   cover property (st.sense[0] && $rose(st.flags[0]));
    c_level_set:  cover property (!st.sense[1] && $rose(st.flags[1]));
    c_sw_clear:   cover property (flags_wr && |sw_clr ##1 !(|st.flags));
    c_ack_clear:  cover property (|auto_clr);
    c_high_wins:  cover property (req_valid_o && req_level_o && |(st.flags & st.enable[5:0] & ~ext_levels(st.prio_a)));

endmodule

// ### ipfes_pkg.sv
// Constants shared by the external request and priority block
package ipfes_pkg;

    // --------------------------------------------------------------
    // Widths
    // --------------------------------------------------------------
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int NUM_IRQ = 6;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_SENSE  = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h05;
    localparam logic [7:0] OFS_FLAGS  = 8'h06;
    localparam logic [7:0] OFS_PRIO_A = 8'h08;
    localparam logic [7:0] OFS_PRIO_B = 8'h09;

    // --------------------------------------------------------------
    // Values after reset and fixed read values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [5:0] RST_FLAGS   = 6'h00;
    localparam logic [7:0] READ_UNMAP  = 8'h00;
    localparam logic [1:0] FLAGS_RSVD  = 2'h0;
    localparam logic [7:0] VEC_BASE    = 8'h0c;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int PA_IRQ0_BIT   = 7;
    localparam int PA_IRQ1_BIT   = 6;
    localparam int PA_IRQ23_BIT  = 5;
    localparam int PA_IRQ45_BIT  = 4;
    localparam int PA_TIMER0_BIT = 2;
    localparam int PA_TIMER1_BIT = 1;
    localparam int PA_TIMER2_BIT = 0;
    localparam int PB_TIMER3_BIT = 7;
    localparam int PB_TIMER4_BIT = 6;
    localparam int PB_DMA_BIT    = 5;
    localparam int PB_SERIAL0_BIT = 3;
    localparam int PB_SERIAL1_BIT = 2;
    localparam int PB_CONV_BIT   = 1;

endpackage

// ### ipfes_core_model.sv
// Behavioural processor core that takes presented external requests
`timescale 1ns/1ps

module ipfes_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ack_en_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       req_valid_i,
    output logic            ack_o
);
    // --------------------------------------------------------------
    // Exception handling after a settable wait
    // --------------------------------------------------------------
    logic [3:0] cnt;

    // After a pulse the count restarts, so a stale valid is never taken twice
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !ack_en_i || !req_valid_i || ack_o) begin
            cnt   <= 4'h0;
            ack_o <= 1'b0;
        end else if (cnt == delay_i) begin
            cnt   <= 4'h0;
            ack_o <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ### ipfes_top_tb.sv
// Self-checking testbench for the external request and priority block
`timescale 1ns/1ps

module ipfes_top_tb;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       standby_n_i = 1'b1;
    logic [5:0] irq_n_i = 6'h3f;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       ack_i;
    logic       ack_en = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [7:0] rdata_o, req_vector_o, a, b;
    logic       req_valid_o, req_level_o, dma_prio_o, converter_prio_o;
    logic [4:0] timer_prio_o;
    logic [1:0] serial_prio_o;
    int         n_errors = 0;
    int         checked = 0;

    always #4 clk_i = ~clk_i;

    ipfes_top u_ipfes_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .standby_n_i(standby_n_i), .irq_n_i(irq_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .ack_i(ack_i), .rdata_o(rdata_o),
        .req_valid_o(req_valid_o), .req_vector_o(req_vector_o), .req_level_o(req_level_o),
        .timer_prio_o(timer_prio_o), .dma_prio_o(dma_prio_o), .serial_prio_o(serial_prio_o),
        .converter_prio_o(converter_prio_o));

    ipfes_core_model u_ipfes_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .ack_en_i(ack_en), .delay_i(dly),
        .req_valid_i(req_valid_o), .ack_o(ack_i));

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= adr;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= adr;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask

    task automatic drive(input logic [5:0] pins, input logic en, input logic [3:0] d);
        @(posedge clk_i);
        irq_n_i <= pins;
        ack_en <= en;
        dly <= d;
    endtask

    task automatic outs(input logic v, input logic [7:0] vec, input logic lvl);
        chk("req_valid", {7'h00, v}, {7'h00, req_valid_o});
        chk("req_vector", vec, req_vector_o);
        chk("req_level", {7'h00, lvl}, {7'h00, req_level_o});
    endtask

    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Watchdog: the sequence needs well under a thousand cycles
    // --------------------------------------------------------------
    initial begin
        repeat (4000) @(posedge clk_i);
        n_errors++;
        final_report();
    end

    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(1);
        outs(1'b0, 8'h0c, 1'b0);
        rd_chk("sense", ipfes_pkg::OFS_SENSE, 8'h00);
        rd_chk("enable", ipfes_pkg::OFS_ENABLE, 8'h00);
        rd_chk("prio_b", ipfes_pkg::OFS_PRIO_B, 8'h00);
        rd_chk("unmapped", 8'h00, 8'h00);
        wr(ipfes_pkg::OFS_FLAGS, 8'hff);
        rd_chk("flags", ipfes_pkg::OFS_FLAGS, 8'h00);
        // Two complementary patterns reach every priority bit both ways
        for (int i = 0; i < 2; i++) begin
            a = i ? 8'h5a : 8'ha5;
            b = ~a;
            wr(ipfes_pkg::OFS_PRIO_A, a);
            wr(ipfes_pkg::OFS_PRIO_B, b);
            // Read strobe straight after the write strobe, with no gap
            addr_i <= ipfes_pkg::OFS_PRIO_B;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1;
            chk("prio_b", b, rdata_o);
            chk("timer", {3'h0, b[6], b[7], a[0], a[1], a[2]}, {3'h0, timer_prio_o});
            chk("dma", {7'h00, b[5]}, {7'h00, dma_prio_o});
            chk("serial", {6'h00, b[2], b[3]}, {6'h00, serial_prio_o});
            chk("conv", {7'h00, b[1]}, {7'h00, converter_prio_o});
        end
        wr(ipfes_pkg::OFS_PRIO_A, 8'h00);
        // Level sense, with spare bits set in sense and enable
        wr(ipfes_pkg::OFS_SENSE, 8'hc0);
        wr(ipfes_pkg::OFS_ENABLE, 8'hc1);
        rd_chk("sense", ipfes_pkg::OFS_SENSE, 8'hc0);
        rd_chk("enable", ipfes_pkg::OFS_ENABLE, 8'hc1);
        drive(6'h3e, 1'b0, 4'h0);
        cyc(5);
        outs(1'b1, 8'h0c, 1'b0);
        drive(6'h3e, 1'b1, 4'h0);
        cyc(6);
        rd_chk("flags", ipfes_pkg::OFS_FLAGS, 8'h01);
        drive(6'h3f, 1'b1, 4'h0);
        cyc(8);
        outs(1'b0, 8'h0c, 1'b0);
        // Edge sense, two requests, then a raised level
        wr(ipfes_pkg::OFS_SENSE, 8'h3f);
        wr(ipfes_pkg::OFS_ENABLE, 8'h3f);
        drive(6'h1b, 1'b0, 4'h5);
        cyc(5);
        outs(1'b1, 8'h0e, 1'b0);
        wr(ipfes_pkg::OFS_PRIO_A, 8'h10);
        cyc(2);
        outs(1'b1, 8'h11, 1'b1);
        drive(6'h1b, 1'b1, 4'h5);
        cyc(20);
        outs(1'b0, 8'h0c, 1'b0);
        rd_chk("flags", ipfes_pkg::OFS_FLAGS, 8'h00);
        // Software clear needs a read of the set flag first
        wr(ipfes_pkg::OFS_ENABLE, 8'h00);
        drive(6'h37, 1'b0, 4'h0);
        cyc(5);
        outs(1'b0, 8'h0c, 1'b0);
        wr(ipfes_pkg::OFS_FLAGS, 8'h00);
        rd_chk("flags", ipfes_pkg::OFS_FLAGS, 8'h08);
        wr(ipfes_pkg::OFS_FLAGS, 8'hf7);
        rd_chk("flags", ipfes_pkg::OFS_FLAGS, 8'h00);
        drive(6'h3f, 1'b0, 4'h0);
        // Hardware standby clears the registers
        wr(ipfes_pkg::OFS_ENABLE, 8'hc3);
        wr(ipfes_pkg::OFS_PRIO_B, 8'hff);
        @(posedge clk_i);
        standby_n_i <= 1'b0;
        cyc(6);
        @(posedge clk_i);
        standby_n_i <= 1'b1;
        cyc(4);
        rd_chk("enable", ipfes_pkg::OFS_ENABLE, 8'h00);
        rd_chk("prio_b", ipfes_pkg::OFS_PRIO_B, 8'h00);
        final_report();
    end
endmodule
